// *** common/wake_ctrl_pkg.sv ***
// Offsets, field positions, reset values and counts for the wake source
// control registers. Assumes a 7-bit register address from the host port.
package wake_ctrl_pkg;

    // ==========================================================
    // Register map
    localparam int ADDR_W = 7;
    localparam logic [6:0] OFF_CAN_MODE = 7'h04;
    localparam logic [6:0] OFF_INT_WAKE = 7'h06;
    localparam logic [6:0] OFF_EXT_WAKE = 7'h07;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_CAN_MODE = 8'h00;
    localparam logic [7:0] RST_INT_WAKE = 8'h00;
    localparam logic [7:0] RST_EXT_WAKE = 8'h01;
    localparam logic [2:0] DEV_CAN_MODE = 3'h3;

    // ==========================================================
    // Field positions
    localparam int BIT_SELECTIVE_WAKE = 2;
    localparam int BIT_TIMER_WAKE = 6;
    localparam int BIT_STOP_WD_OFF1 = 2;
    localparam int BIT_INT_GLOBAL = 7;
    localparam int BIT_SENSE_SEL = 5;
    localparam int BIT_HV_WAKE_EN = 0;

    // ==========================================================
    // Counts
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam logic [3:0] INT_LOW_CYCLES = 4'h4;

    typedef enum logic [1:0] {
        CAN_OFF = 2'b00,
        CAN_WAKE = 2'b01,
        CAN_RX_ONLY = 2'b10,
        CAN_NORMAL = 2'b11
    } can_mode_t;

endpackage : wake_ctrl_pkg

// *** rtl/can_mode_decode.sv ***
// Decodes the three-bit transceiver mode field into registered controls.
// Assumes the field comes from a register on the same clock.
`timescale 1ns/1ps
module can_mode_decode (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] mode_field,
    output logic can_off,
    output logic can_wake_capable,
    output logic can_rx_only,
    output logic can_normal,
    output logic selective_wake
);
    import wake_ctrl_pkg::*;

    // ==========================================================
    // Decode
    wire can_mode_t low_mode = can_mode_t'(mode_field[1:0]);
    wire off_next = (low_mode == CAN_OFF);
    // Code 100 is off as well, so no selective wake there
    wire swk_next = mode_field[BIT_SELECTIVE_WAKE] && !off_next;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            can_off <= 1'b1;
            can_wake_capable <= 1'b0;
            can_rx_only <= 1'b0;
            can_normal <= 1'b0;
            selective_wake <= 1'b0;
        end else begin
            can_off <= off_next;
            can_wake_capable <= (low_mode == CAN_WAKE);
            can_rx_only <= (low_mode == CAN_RX_ONLY);
            can_normal <= (low_mode == CAN_NORMAL);
            selective_wake <= swk_next;
        end
    end

    // ==========================================================
    // Checks
    a_decode_normal_swk: assert property (
        @(posedge clk) disable iff (sys_rst)
        (mode_field == 3'h7) |=> (can_normal && selective_wake && !can_off))
        else $error("mode 111 not decoded as normal with selective wake");

    a_decode_off_code4: assert property (
        @(posedge clk) disable iff (sys_rst)
        (mode_field == 3'h4) |=> (can_off && !selective_wake))
        else $error("mode 100 not decoded as off");

endmodule : can_mode_decode

// *** rtl/interrupt_gen.sv ***
// Drives the active-low interrupt output from wake and status events.
// Assumes one-cycle event pulses on the same clock.
`timescale 1ns/1ps
module interrupt_gen (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wake_event,
    input wire logic status_event,
    input wire logic int_global,
    output logic interrupt_out_n
);
    import wake_ctrl_pkg::*;

    // ==========================================================
    // Source select and pulse stretch
    wire int_trigger = wake_event || (int_global && status_event);
    logic [3:0] low_cnt_reg;
    logic [3:0] low_cnt_next;

    // Retrigger restarts the low time rather than being lost
    assign low_cnt_next = int_trigger ? INT_LOW_CYCLES :
                          (low_cnt_reg != 4'h0) ? low_cnt_reg - 4'h1 : 4'h0;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_cnt_reg <= 4'h0;
            interrupt_out_n <= 1'b1;
        end else begin
            low_cnt_reg <= low_cnt_next;
            interrupt_out_n <= (low_cnt_next == 4'h0);
        end
    end

    // ==========================================================
    // Checks
    a_interrupt_out_n_wake_source: assert property (
        @(posedge clk) disable iff (sys_rst)
        wake_event |=> !interrupt_out_n [*4])
        else $error("wake event did not hold interrupt low");

    a_interrupt_out_n_status_masked: assert property (
        @(posedge clk) disable iff (sys_rst)
        (interrupt_out_n && low_cnt_reg == 4'h0 && !wake_event && !int_global)
        |=> interrupt_out_n)
        else $error("status event raised interrupt with global select clear");

endmodule : interrupt_gen

// *** rtl/can_wake_source_control_regs.sv ***
// Transceiver mode and wake source control registers with their
// hardware updates on sleep, stop, fail-safe, restart and soft reset.
// Assumes the serial host port delivers decoded one-cycle write and read
// requests, and mode transition events arrive as same-clock pulses.
`timescale 1ns/1ps
module can_wake_source_control_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [wake_ctrl_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    input wire logic [wake_ctrl_pkg::ADDR_W-1:0] rd_addr,
    input wire logic soft_reset,
    input wire logic sleep_entry,
    input wire logic stop_entry,
    input wire logic stop_to_normal,
    input wire logic failsafe_entry,
    input wire logic restart_entry,
    input wire logic [1:0] restart_can_mode,
    input wire logic system_error_flag,
    input wire logic fail_signal_output,
    input wire logic normal_mode,
    input wire logic timer_wake_event,
    input wire logic can_wake_event,
    input wire logic status_event,
    input wire logic dev_mode_strap,
    input wire logic hv_wake_input,
    input wire logic general_pin_in,
    output logic [7:0] rd_data,
    output logic can_off,
    output logic can_wake_capable,
    output logic can_rx_only,
    output logic can_normal,
    output logic selective_wake,
    output logic timer_wake_enable,
    output logic stop_watchdog_off_bit1,
    output logic voltage_sense_select,
    output logic hv_input_wake_enable,
    output logic measurement_active,
    output logic hv_input_level_status,
    output logic general_pin_level_status,
    output logic hv_wake_event,
    output logic spi_fail_set,
    output logic interrupt_out_n
);
    import wake_ctrl_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // Bit 0 wake input, bit 1 general pin, bit 2 development strap
    wire [2:0] pin_async = {dev_mode_strap, general_pin_in, hv_wake_input};
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pin_async[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    wire hv_sync = sync2_reg[0];
    wire gp_sync = sync2_reg[1];
    wire dev_sync = sync2_reg[2];

    // ==========================================================
    // Register state
    logic [2:0] can_reg;
    logic [2:0] can_next;
    logic timer_wake_reg;
    logic timer_wake_next;
    logic wd_off1_reg;
    logic wd_off1_next;
    logic int_global_reg;
    logic int_global_next;
    logic sense_reg;
    logic sense_next;
    logic hv_en_reg;
    logic hv_en_next;
    logic [1:0] strap_cnt_reg;
    logic hv_prev_reg;

    // ==========================================================
    // Write decode
    wire wr_can = wr_en && (wr_addr == OFF_CAN_MODE);
    wire wr_iwk = wr_en && (wr_addr == OFF_INT_WAKE);
    wire wr_ewk = wr_en && (wr_addr == OFF_EXT_WAKE);
    // Strap is only trusted once the synchroniser has settled after reset
    wire strap_apply = (strap_cnt_reg == 2'h1) && dev_sync;
    wire [2:0] soft_can = dev_sync ? DEV_CAN_MODE : RST_CAN_MODE[2:0];
    wire sense_refused = wr_ewk && wr_data[BIT_SENSE_SEL] && fail_signal_output;

    // ==========================================================
    // Transceiver mode field
    always_comb begin
        can_next = can_reg;
        if (wr_can) begin
            can_next = wr_data[2:0];
        end
        // Sleep, fail-safe and restart touch only bits 1:0; bit 2 changes only on host write, strap or soft reset
        if (sleep_entry && !system_error_flag && can_reg[1:0] == CAN_NORMAL) begin
            can_next[1:0] = CAN_WAKE;
        end
        if (sleep_entry && can_reg[1:0] == CAN_RX_ONLY) begin
            can_next[1:0] = CAN_WAKE;
        end
        // Stop entry and wake capable/off modes leave the field alone
        if (failsafe_entry) begin
            can_next[1:0] = CAN_WAKE;
        end
        if (restart_entry) begin
            can_next[1:0] = restart_can_mode;
        end
        if (strap_apply) begin
            can_next = DEV_CAN_MODE;
        end
        if (soft_reset) begin
            can_next = soft_can;
        end
    end

    // ==========================================================
    // Internal wake register
    always_comb begin
        timer_wake_next = timer_wake_reg;
        wd_off1_next = wd_off1_reg;
        if (stop_to_normal) begin
            wd_off1_next = 1'b0;
        end
        // Host write comes after the stop clear so a set in the clearing cycle wins
        if (wr_iwk) begin
            timer_wake_next = wr_data[BIT_TIMER_WAKE];
            wd_off1_next = wr_data[BIT_STOP_WD_OFF1];
        end
        if (restart_entry) begin
            wd_off1_next = 1'b0;
        end
        if (soft_reset) begin
            timer_wake_next = RST_INT_WAKE[BIT_TIMER_WAKE];
            wd_off1_next = RST_INT_WAKE[BIT_STOP_WD_OFF1];
        end
    end

    // ==========================================================
    // External wake register
    always_comb begin
        int_global_next = int_global_reg;
        sense_next = sense_reg;
        hv_en_next = hv_en_reg;
        if (wr_ewk) begin
            int_global_next = wr_data[BIT_INT_GLOBAL];
            sense_next = wr_data[BIT_SENSE_SEL] && !fail_signal_output;
            hv_en_next = wr_data[BIT_HV_WAKE_EN];
        end
        // Bits 7 and 5 are kept, the wake input re-armed
        if (failsafe_entry && !sense_reg) begin
            hv_en_next = 1'b1;
        end
        // With sensing on the enable is left as it was
        if (soft_reset) begin
            int_global_next = RST_EXT_WAKE[BIT_INT_GLOBAL];
            sense_next = RST_EXT_WAKE[BIT_SENSE_SEL];
            hv_en_next = RST_EXT_WAKE[BIT_HV_WAKE_EN];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            can_reg <= RST_CAN_MODE[2:0];
            timer_wake_reg <= RST_INT_WAKE[BIT_TIMER_WAKE];
            wd_off1_reg <= RST_INT_WAKE[BIT_STOP_WD_OFF1];
            int_global_reg <= RST_EXT_WAKE[BIT_INT_GLOBAL];
            sense_reg <= RST_EXT_WAKE[BIT_SENSE_SEL];
            hv_en_reg <= RST_EXT_WAKE[BIT_HV_WAKE_EN];
            strap_cnt_reg <= STRAP_SETTLE;
        end else begin
            can_reg <= can_next;
            timer_wake_reg <= timer_wake_next;
            wd_off1_reg <= wd_off1_next;
            int_global_reg <= int_global_next;
            sense_reg <= sense_next;
            hv_en_reg <= hv_en_next;
            strap_cnt_reg <= (strap_cnt_reg != 2'h0) ? strap_cnt_reg - 2'h1 : 2'h0;
        end
    end

    // ==========================================================
    // Wake input: detection or sensing
    wire hv_wake_live = hv_en_reg && !sense_reg;
    wire hv_rise = hv_sync && !hv_prev_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hv_prev_reg <= 1'b0;
            hv_input_level_status <= 1'b0;
            general_pin_level_status <= 1'b0;
            hv_wake_event <= 1'b0;
            measurement_active <= 1'b0;
            spi_fail_set <= 1'b0;
        end else begin
            hv_prev_reg <= hv_sync;
            hv_input_level_status <= hv_sync && !sense_reg;
            general_pin_level_status <= gp_sync && !sense_reg;
            hv_wake_event <= hv_rise && hv_wake_live;
            measurement_active <= sense_reg && normal_mode;
            spi_fail_set <= sense_refused;
        end
    end

    // ==========================================================
    // Read back, reserved bits as zero
    wire [7:0] can_rd = {5'h00, can_reg};
    wire [7:0] iwk_rd = {1'b0, timer_wake_reg, 3'h0, wd_off1_reg, 2'h0};
    wire [7:0] ewk_rd = {int_global_reg, 1'b0, sense_reg, 4'h0, hv_en_reg};
    wire [7:0] rd_sel = (rd_addr == OFF_CAN_MODE) ? can_rd :
                        (rd_addr == OFF_INT_WAKE) ? iwk_rd :
                        (rd_addr == OFF_EXT_WAKE) ? ewk_rd : 8'h00;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
            timer_wake_enable <= 1'b0;
            stop_watchdog_off_bit1 <= 1'b0;
            voltage_sense_select <= 1'b0;
            hv_input_wake_enable <= 1'b0;
        end else begin
            if (rd_en) begin
                rd_data <= rd_sel;
            end
            timer_wake_enable <= timer_wake_reg;
            stop_watchdog_off_bit1 <= wd_off1_reg;
            voltage_sense_select <= sense_reg;
            hv_input_wake_enable <= hv_wake_live;
        end
    end

    // ==========================================================
    // Decode and interrupt
    can_mode_decode u_decode (
        .clk(clk),
        .sys_rst(sys_rst),
        .mode_field(can_reg),
        .can_off(can_off),
        .can_wake_capable(can_wake_capable),
        .can_rx_only(can_rx_only),
        .can_normal(can_normal),
        .selective_wake(selective_wake)
    );

    // Timer wakes only count while enabled as a wake source
    wire any_wake = hv_wake_event || can_wake_event || (timer_wake_event && timer_wake_reg);

    interrupt_gen u_int (
        .clk(clk),
        .sys_rst(sys_rst),
        .wake_event(any_wake),
        .status_event(status_event),
        .int_global(int_global_reg),
        .interrupt_out_n(interrupt_out_n)
    );

    // ==========================================================
    // Checks
    wire can_hw_quiet = !wr_can && !failsafe_entry && !restart_entry
                        && !soft_reset && !strap_apply;

    sequence s_sense_refused;
        wr_ewk && wr_data[BIT_SENSE_SEL] && fail_signal_output;
    endsequence

    a_sleep_normal_wake: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleep_entry && can_hw_quiet && !system_error_flag && can_reg[1:0] == 2'h3)
        |=> (can_reg[1:0] == 2'h1 && $stable(can_reg[2])))
        else $error("normal mode not turned wake capable on sleep");

    a_stop_keeps_rx: assert property (
        @(posedge clk) disable iff (sys_rst)
        (stop_entry && !sleep_entry && can_hw_quiet) |=> $stable(can_reg))
        else $error("stop entry changed the transceiver mode");

    a_sleep_keeps_wake: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sleep_entry && can_hw_quiet && !can_reg[1]) |=> $stable(can_reg))
        else $error("sleep entry changed wake capable or off mode");

    a_swk_host_only: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!wr_can && !soft_reset && !strap_apply) |=> $stable(can_reg[2]))
        else $error("selective wake bit changed without a host write");

    a_failsafe_wake: assert property (
        @(posedge clk) disable iff (sys_rst)
        (failsafe_entry && !restart_entry && !soft_reset && !strap_apply)
        |=> (can_reg[1:0] == 2'h1) ##1 can_wake_capable)
        else $error("fail-safe entry did not force wake capable");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        (rd_en && rd_addr == OFF_CAN_MODE) |=> (rd_data[7:3] == 5'h00))
        else $error("reserved transceiver bits read nonzero");

    a_sense_refused: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_sense_refused and (!soft_reset) |=> (!sense_reg && spi_fail_set))
        else $error("sense select accepted while fail output active");

    a_wd_clear_stop: assert property (
        @(posedge clk) disable iff (sys_rst)
        (stop_to_normal && !wr_iwk) |=> !wd_off1_reg ##1 !stop_watchdog_off_bit1)
        else $error("stop watchdog off bit survived stop to normal");

    a_restart_timer: assert property (
        @(posedge clk) disable iff (sys_rst)
        (restart_entry && !wr_iwk && !soft_reset) |=> ($stable(timer_wake_reg) && !wd_off1_reg))
        else $error("restart did not keep timer enable and clear the rest");

    a_failsafe_hv_en: assert property (
        @(posedge clk) disable iff (sys_rst)
        (failsafe_entry && !sense_reg && !soft_reset) |=> hv_en_reg ##1 hv_input_wake_enable)
        else $error("fail-safe entry did not enable the wake input");

    a_sense_holds_level: assert property (
        @(posedge clk) disable iff (sys_rst)
        (sense_reg && !soft_reset && !wr_ewk) [*2]
        |=> (!hv_input_level_status && !general_pin_level_status && !hv_wake_event))
        else $error("level status or wake event updated while sensing");

endmodule : can_wake_source_control_regs

// *** sim/host_model.sv ***
// Host controller side of the register port: one-cycle write and read requests.
// Assumes the block samples requests and returns read data on rising clk edges.
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic wr_en,
    output logic [wake_ctrl_pkg::ADDR_W-1:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_en,
    output logic [wake_ctrl_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [7:0] rd_data
);
    import wake_ctrl_pkg::*;

    // ==========================================================
    // Requests
    initial begin
        wr_en = 1'b0;
        wr_addr = 7'h00;
        wr_data = 8'h00;
        rd_en = 1'b0;
        rd_addr = 7'h00;
    end

    // Data is inverted once released so a stale byte never looks valid
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_data <= ~d;
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd
endmodule : host_model

// *** sim/tb.sv ***
// Self-checking bench for the wake source control registers.
// Assumes host_model drives the register port; events are driven here.
`timescale 1ns/1ps
module tb;
    import wake_ctrl_pkg::*;

    // ==========================================================
    // Stimulus and monitors
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] ev = 8'h00;
    logic [1:0] rs_mode = 2'h0;
    logic err_flag = 1'b0;
    logic fail_out = 1'b0;
    logic norm = 1'b0;
    logic strap = 1'b0;
    logic hv_in = 1'b0;
    logic wr_en, rd_en, spi_fail, hv_ev, irq_n, off, wk, rx, nrm, sel, tmr, wdo, vs, hve, meas, hvl;
    logic [6:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data;
    logic [2:0] seen = 3'h0;
    logic clr = 1'b0;
    logic gp_in = 1'b0;
    logic gpl;
    int num_errors = 0;
    int comparisons = 0;
    logic [2:0] st_m [6] = '{3'h3, 3'h7, 3'h2, 3'h2, 3'h1, 3'h0};
    int st_e [6] = '{0, 0, 0, 1, 0, 1};
    logic [2:0] st_x [6] = '{3'h1, 3'h5, 3'h1, 3'h2, 3'h1, 3'h0};

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        seen <= clr ? 3'h0 : (seen | {spi_fail, hv_ev, ~irq_n});
    end

    host_model host_u (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));

    can_wake_source_control_regs dut_u (.clk(clk), .sys_rst(sys_rst), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
        .soft_reset(ev[5]), .sleep_entry(ev[0]), .stop_entry(ev[1]),
        .stop_to_normal(ev[2]), .failsafe_entry(ev[3]), .restart_entry(ev[4]),
        .restart_can_mode(rs_mode), .system_error_flag(err_flag),
        .fail_signal_output(fail_out), .normal_mode(norm), .timer_wake_event(ev[7]),
        .can_wake_event(1'b0), .status_event(ev[6]), .dev_mode_strap(strap),
        .hv_wake_input(hv_in), .general_pin_in(gp_in), .rd_data(rd_data), .can_off(off),
        .can_wake_capable(wk), .can_rx_only(rx), .can_normal(nrm), .selective_wake(sel),
        .timer_wake_enable(tmr), .stop_watchdog_off_bit1(wdo), .voltage_sense_select(vs),
        .hv_input_wake_enable(hve), .measurement_active(meas), .hv_input_level_status(hvl),
        .general_pin_level_status(gpl), .hv_wake_event(hv_ev), .spi_fail_set(spi_fail),
        .interrupt_out_n(irq_n));

    // ==========================================================
    // Helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd(a, d);
        check(d, exp);
    endtask : rchk

    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : pulse

    // Sticky flags are cleared by their own process, never from the sequence
    task automatic clear_seen();
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask : clear_seen

    task automatic results();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // Hang guard: far above the length of the sequence below
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        results();
    end

    // ==========================================================
    // Sequence
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        rchk(7'h04, 8'h00);
        rchk(7'h06, 8'h00);
        rchk(7'h07, 8'h01);
        rchk(7'h05, 8'h00);
        host_u.wr(7'h04, 8'hFF);
        host_u.wr(7'h06, 8'hFF);
        host_u.wr(7'h07, 8'hFF);
        rchk(7'h04, 8'h07);
        rchk(7'h06, 8'h44);
        rchk(7'h07, 8'hA1);
        $display("test reset_reserved done");
        for (int m = 0; m < 8; m++) begin
            host_u.wr(7'h04, 8'(m));
            repeat (3) @(posedge clk);
            #1;
            check({3'h0, sel, off, wk, rx, nrm},
                {3'h0, m[2] & (m[1:0] != 2'h0), 4'h8 >> m[1:0]});
        end
        $display("test decode done");
        // Receive-only before stop is the host's job, so the table sets it first
        for (int i = 0; i < 6; i++) begin
            host_u.wr(7'h04, {5'h00, st_m[i]});
            pulse(st_e[i]);
            rchk(7'h04, {5'h00, st_x[i]});
        end
        err_flag <= 1'b1;
        host_u.wr(7'h04, 8'h03);
        pulse(0);
        rchk(7'h04, 8'h03);
        err_flag <= 1'b0;
        $display("test sleep_stop done");
        host_u.wr(7'h04, 8'h07);
        host_u.wr(7'h07, 8'h80);
        pulse(3);
        rchk(7'h04, 8'h05);
        rchk(7'h07, 8'h81);
        host_u.wr(7'h07, 8'h20);
        pulse(3);
        rchk(7'h07, 8'h20);
        $display("test failsafe done");
        rs_mode <= 2'h2;
        host_u.wr(7'h04, 8'h07);
        host_u.wr(7'h06, 8'h44);
        pulse(4);
        rchk(7'h04, 8'h06);
        rchk(7'h06, 8'h40);
        host_u.wr(7'h06, 8'h44);
        pulse(0);
        check({6'h0, tmr, wdo}, 8'h03);
        pulse(2);
        rchk(7'h06, 8'h40);
        $display("test restart_stop done");
        fail_out <= 1'b1;
        host_u.wr(7'h07, 8'h01);
        clear_seen();
        host_u.wr(7'h07, 8'h21);
        repeat (3) @(posedge clk);
        #1;
        check({7'h0, seen[2]}, 8'h01);
        rchk(7'h07, 8'h01);
        fail_out <= 1'b0;
        norm <= 1'b1;
        host_u.wr(7'h07, 8'h21);
        clear_seen();
        hv_in <= 1'b1;
        gp_in <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        check({2'h0, vs, gpl, meas, hve, hvl, seen[1]}, 8'h28);
        hv_in <= 1'b0;
        host_u.wr(7'h07, 8'h01);
        repeat (4) @(posedge clk);
        clear_seen();
        hv_in <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        check({3'h0, gpl, hve, hvl, seen[1:0]}, 8'h1F);
        $display("test sensing done");
        clear_seen();
        pulse(7);
        check({7'h0, seen[0]}, 8'h01);
        host_u.wr(7'h06, 8'h00);
        clear_seen();
        pulse(7);
        check({7'h0, seen[0]}, 8'h00);
        clear_seen();
        pulse(6);
        repeat (4) @(posedge clk);
        check({7'h0, seen[0]}, 8'h00);
        host_u.wr(7'h07, 8'h81);
        clear_seen();
        pulse(6);
        repeat (4) @(posedge clk);
        check({7'h0, seen[0]}, 8'h01);
        $display("test interrupt done");
        strap <= 1'b1;
        repeat (4) @(posedge clk);
        pulse(5);
        rchk(7'h04, 8'h03);
        rchk(7'h06, 8'h00);
        rchk(7'h07, 8'h01);
        $display("test soft_reset done");
        results();
    end
endmodule : tb
